// *** rtl/gdb_top.sv ***
// data and level registers for 64 general-purpose pins, event registers for 32 of them
// assumes i/o port strobes are synchronous to clk_sys, one cycle each;
// lock and edge sense come from the per-pin configuration logic
// pin enables, buffer types and pull-ups live outside this block
//
// Notes on behaviour
// - low output bits drive pins 0-31
// - locked pins keep their output latch
// - output registers read back latched values
// - high output bits drive pins 32-63
// - level registers show current pin levels
// - level registers read-only, writes ignored
// - low enables gate events of pins 0-15
// - enabled events OR into aggregate status
// - one select bit routes control/management interrupt
// - control interrupt also needs global enable
// - management route asserts interrupt and top status
// - chosen edge sets status, maybe event
// - status sticky until software writes one
// - management clear also clears upper levels
// - control route leaves top status alone
// - select bit 5 picks the bank
// - reset: outputs 0fffffff per bank, others zero
// - select bits 4:0 pick the pin
// - edge sense 0 falling, 1 rising
// - lock freezes output value until reset
`timescale 1ns/1ps
module gdb_top (
	input  wire logic                       clk_sys,
	input  wire logic                       rst_n,
	input  wire logic [gdb_pkg::ADDR_W-1:0] io_addr,
	input  wire logic                       io_wr,
	input  wire logic                       io_rd,
	input  wire logic [31:0]                io_wdata,
	output logic      [31:0]                io_rdata,
	input  wire logic [gdb_pkg::NPINS-1:0]  pin_in,
	output logic      [gdb_pkg::NPINS-1:0]  pin_out,
	input  wire logic [gdb_pkg::NPINS-1:0]  pin_lock,
	input  wire logic [gdb_pkg::NPINS-1:0]  event_edge_sense,
	input  wire logic                       route_sel,
	input  wire logic                       sci_global_en,
	output logic                            pme_aggregate,
	output logic                            sci_req,
	output logic                            smi_req,
	output logic                            smi_second_sts,
	output logic                            smi_top_sts,
	output logic                            cfg_bank,
	output logic      [4:0]                 cfg_pin
);
	localparam int unsigned EW = gdb_pkg::EVT_W;
	localparam int unsigned BW = gdb_pkg::BANK_W;

	gdb_pin_if pins ();  // synchronised levels and edges

	// pin synchroniser and edge detector
	gdb_pin_sync u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.pin_in  (pin_in),
		.pins    (pins)
	);

	// write decode shared by every writable register
	// one decode per register keeps the strobes uniform
	function automatic logic hit(input logic [gdb_pkg::ADDR_W-1:0] a,
	                             input logic [gdb_pkg::ADDR_W-1:0] off,
	                             input logic                       wr);
		hit = wr && (a == off);
	endfunction

	// register state
	// reserved upper halves of event registers are not stored
	logic [BW-1:0]           out_lo_q, out_lo_d;   // low output latch
	logic [BW-1:0]           out_hi_q, out_hi_d;   // high output latch
	logic [EW-1:0]           een_lo_q, een_lo_d;   // low event enables
	logic [EW-1:0]           een_hi_q, een_hi_d;   // high event enables
	logic [EW-1:0]           est_lo_q, est_lo_d;   // low edge status
	logic [EW-1:0]           est_hi_q, est_hi_d;   // high edge status
	logic [gdb_pkg::CSEL_W-1:0] csel_q, csel_d;    // bank and pin select
	logic [31:0]             rdata_q, rdata_d;     // read data
	logic                    agg_q, agg_d;         // aggregate event
	logic                    sci_q, sci_d;         // control interrupt
	logic                    smi_q, smi_d;         // management interrupt
	logic                    s2_q, s2_d;           // second-level status
	logic                    s1_q, s1_d;           // top-level status

	// per event pin edge choice
	logic [EW-1:0] hit_lo;  // chosen edge seen, pins 0-15
	logic [EW-1:0] hit_hi;  // chosen edge seen, pins 32-47

	// only pins 0-15 and 32-47 can raise events; the others have
	// no edge status at all, which saves 32 sticky flops
	// pick edge per sense
	generate
		for (genvar i = 0; i < EW; i++) begin : g_edge
			assign hit_lo[i] = event_edge_sense[i] ? pins.rise[i]
			                                         : pins.fall[i];
			assign hit_hi[i] = event_edge_sense[BW+i] ? pins.rise[BW+i]
			                                            : pins.fall[BW+i];
		end
	endgenerate

	// write strobes
	// offsets decode only with io_wr high; a read never disturbs
	// state, so io_rd and io_wr may share a cycle
	logic wr_out_lo, wr_out_hi, wr_een_lo, wr_een_hi;
	logic wr_est_lo, wr_est_hi, wr_csel;
	logic [EW-1:0] clr_lo, clr_hi;     // status bits software clears
	logic [EW-1:0] new_evt;            // enabled edges this cycle
	logic          any_clear;          // a w1c write cleared a set bit

	always_comb begin
		wr_out_lo = hit(io_addr, gdb_pkg::OFF_OUT_LO, io_wr);
		wr_out_hi = hit(io_addr, gdb_pkg::OFF_OUT_HI, io_wr);
		wr_een_lo = hit(io_addr, gdb_pkg::OFF_EEN_LO, io_wr);
		wr_een_hi = hit(io_addr, gdb_pkg::OFF_EEN_HI, io_wr);
		wr_est_lo = hit(io_addr, gdb_pkg::OFF_EST_LO, io_wr);
		wr_est_hi = hit(io_addr, gdb_pkg::OFF_EST_HI, io_wr);
		wr_csel   = hit(io_addr, gdb_pkg::OFF_CSEL, io_wr);
		clr_lo    = wr_est_lo ? io_wdata[EW-1:0] : '0;
		clr_hi    = wr_est_hi ? io_wdata[EW-1:0] : '0;
		new_evt   = (hit_lo & een_lo_d) | (hit_hi & een_hi_d);
		any_clear = |((clr_lo & est_lo_q) | (clr_hi & est_hi_q));
	end

	// data-out and configuration next values
	always_comb begin
		out_lo_d = out_lo_q;
		out_hi_d = out_hi_q;
		een_lo_d = een_lo_q;
		een_hi_d = een_hi_q;
		csel_d   = csel_q;
		if (wr_out_lo) begin
			out_lo_d = (io_wdata & ~pin_lock[BW-1:0])
			         | (out_lo_q & pin_lock[BW-1:0]);
		end
		if (wr_out_hi) begin
			out_hi_d = (io_wdata & ~pin_lock[gdb_pkg::NPINS-1:BW])
			         | (out_hi_q & pin_lock[gdb_pkg::NPINS-1:BW]);
		end
		// reserved upper bits are dropped, not stored
		if (wr_een_lo) begin
			een_lo_d = io_wdata[EW-1:0];
		end
		if (wr_een_hi) begin
			een_hi_d = io_wdata[EW-1:0];
		end
		if (wr_csel) begin
			csel_d = io_wdata[gdb_pkg::CSEL_W-1:0];
		end
	end

	// edge status next values
	// an edge in the cycle of its clearing write wins, so software
	// never loses an event it has not yet seen
	always_comb begin
		est_lo_d = (est_lo_q & ~clr_lo) | hit_lo;
		est_hi_d = (est_hi_q & ~clr_hi) | hit_hi;
	end

	// interrupt routing next values
	always_comb begin
		agg_d = |((est_lo_d & een_lo_d) | (est_hi_d & een_hi_d));
		sci_d = agg_d && (route_sel != gdb_pkg::ROUTE_SMI) && sci_global_en;
		// sci_q falls on the clock edge after the global enable drops
		// route select
		s2_d = s2_q;
		s1_d = s1_q;
		// in the management route, a write that clears a set status bit drops both levels;
		// per-bit tracking of the cause was traded for size
		// clearing third level clears upper levels
		if (any_clear && (route_sel == gdb_pkg::ROUTE_SMI)) begin
			s2_d = 1'b0;
			s1_d = 1'b0;
		end
		// management event sets both; set beats clear
		if ((|new_evt) && (route_sel == gdb_pkg::ROUTE_SMI)) begin
			s2_d = 1'b1;
			s1_d = 1'b1;
		end
		smi_d = s1_d;
	end

	// read data; sampled on the read strobe, valid one cycle later
	// reads have no side effect on any status bit
	always_comb begin
		rdata_d = rdata_q;
		if (io_rd) begin
			if (io_addr == gdb_pkg::OFF_OUT_LO) begin
				rdata_d = out_lo_q;
			end else if (io_addr == gdb_pkg::OFF_OUT_HI) begin
				rdata_d = out_hi_q;
			end else if (io_addr == gdb_pkg::OFF_LVL_LO) begin
				rdata_d = pins.level[BW-1:0];
			end else if (io_addr == gdb_pkg::OFF_LVL_HI) begin
				rdata_d = pins.level[gdb_pkg::NPINS-1:BW];
			end else if (io_addr == gdb_pkg::OFF_EEN_LO) begin
				rdata_d = {16'h0000, een_lo_q};
			end else if (io_addr == gdb_pkg::OFF_EEN_HI) begin
				rdata_d = {16'h0000, een_hi_q};
			// status reads never clear; only a write of one does
			end else if (io_addr == gdb_pkg::OFF_EST_LO) begin
				rdata_d = {16'h0000, est_lo_q};
			end else if (io_addr == gdb_pkg::OFF_EST_HI) begin
				rdata_d = {16'h0000, est_hi_q};
			end else if (io_addr == gdb_pkg::OFF_CSEL) begin
				// upper select bits are reserved and read zero
				rdata_d = {{(BW - gdb_pkg::CSEL_W){1'b0}}, csel_q};
			end else begin
				// unmapped offsets read as zero
				rdata_d = gdb_pkg::RD_ZERO;
			end
		end
	end

	// no writes to level registers: no strobe decodes them
	// so a write there changes nothing and has no side effect
	// reset values for latches and configuration
	// lock only blocks writes; reset still restores the latch
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			// latches come up 0fffffff, so pins 28-31 and 60-63 start low
			out_lo_q <= gdb_pkg::RST_OUT;
			out_hi_q <= gdb_pkg::RST_OUT;
			een_lo_q <= gdb_pkg::RST_EVT;
			een_hi_q <= gdb_pkg::RST_EVT;
			csel_q   <= gdb_pkg::RST_CSEL;
		end else begin
			out_lo_q <= out_lo_d;
			out_hi_q <= out_hi_d;
			een_lo_q <= een_lo_d;
			een_hi_q <= een_hi_d;
			csel_q   <= csel_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			est_lo_q <= gdb_pkg::RST_EVT;
			est_hi_q <= gdb_pkg::RST_EVT;
		end else begin
			est_lo_q <= est_lo_d;
			est_hi_q <= est_hi_d;
		end
	end

	// interrupt levels; all quiet after reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			agg_q <= 1'b0;
			sci_q <= 1'b0;
			smi_q <= 1'b0;
			s2_q  <= 1'b0;
			s1_q  <= 1'b0;
		end else begin
			agg_q <= agg_d;
			sci_q <= sci_d;
			smi_q <= smi_d;
			s2_q  <= s2_d;
			s1_q  <= s1_d;
		end
	end

	// read data register; keeps io_rdata steady between reads
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rdata_q <= gdb_pkg::RD_ZERO;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// outputs straight from the registers above
	// io_rdata holds until the next read strobe
	// latch drives pins
	assign pin_out        = {out_hi_q, out_lo_q};
	assign io_rdata       = rdata_q;
	assign pme_aggregate  = agg_q;
	assign sci_req        = sci_q;
	assign smi_req        = smi_q;
	assign smi_second_sts = s2_q;
	assign smi_top_sts    = s1_q;
	assign cfg_bank       = csel_q[gdb_pkg::CSEL_BANK];
	assign cfg_pin        = csel_q[gdb_pkg::CSEL_PIN_H:0];
endmodule

// *** rtl/gdb_pkg.sv ***
// constants for the gpio data and event bank
// assumes one system clock; offsets are i/o byte offsets from the base
package gdb_pkg;
	localparam int unsigned NPINS     = 64;        // pins over two banks
	localparam int unsigned BANK_W    = 32;        // pins per bank
	localparam int unsigned EVT_W     = 16;        // event pins per bank
	localparam int unsigned ADDR_W    = 6;         // i/o offset width
	localparam int unsigned CSEL_W    = 6;         // stored select bits

	// register offsets
	localparam logic [5:0] OFF_OUT_LO  = 6'h00;
	localparam logic [5:0] OFF_LVL_LO  = 6'h04;
	localparam logic [5:0] OFF_EEN_LO  = 6'h08;
	localparam logic [5:0] OFF_EST_LO  = 6'h0c;
	localparam logic [5:0] OFF_OUT_HI  = 6'h10;
	localparam logic [5:0] OFF_LVL_HI  = 6'h14;
	localparam logic [5:0] OFF_EEN_HI  = 6'h18;
	localparam logic [5:0] OFF_EST_HI  = 6'h1c;
	localparam logic [5:0] OFF_CSEL    = 6'h20;

	// reset values
	localparam logic [31:0] RST_OUT    = 32'h0fffffff;
	localparam logic [15:0] RST_EVT    = 16'h0000;
	localparam logic [5:0]  RST_CSEL   = 6'h00;
	localparam logic [31:0] RD_ZERO    = 32'h00000000;

	// config select fields
	localparam int unsigned CSEL_BANK  = 5;
	localparam int unsigned CSEL_PIN_H = 4;

	// routing select values: selects management vs control interrupt
	localparam logic ROUTE_SMI = 1'b0;
endpackage

// *** rtl/gdb_pin_if.sv ***
// carries synchronised pin levels and edges between bank modules
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface gdb_pin_if;
	logic [gdb_pkg::NPINS-1:0] level;  // synchronised pin level
	logic [gdb_pkg::NPINS-1:0] rise;   // one-cycle rising edge
	logic [gdb_pkg::NPINS-1:0] fall;   // one-cycle falling edge
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface

// *** rtl/gdb_pin_sync.sv ***
// two-flop synchroniser and edge detector for all pins
// assumes pin_in is asynchronous to clk_sys
`timescale 1ns/1ps
module gdb_pin_sync (
	input  wire logic                      clk_sys,
	input  wire logic                      rst_n,
	input  wire logic [gdb_pkg::NPINS-1:0] pin_in,
	gdb_pin_if.src                         pins
);
	logic [gdb_pkg::NPINS-1:0] meta_q, meta_d;  // first stage, read once
	logic [gdb_pkg::NPINS-1:0] sync_q, sync_d;  // second stage
	logic [gdb_pkg::NPINS-1:0] prev_q, prev_d;  // last level, edge ref

	// next values; only sync_q and its copy prev_q feed the edge logic
	always_comb begin
		meta_d = pin_in;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	// registers; all ones at reset so no false fall appears
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign pins.level = sync_q;
	assign pins.rise  = sync_q & ~prev_q;
	assign pins.fall  = ~sync_q & prev_q;
endmodule

// *** dv/gdb_pin_model.sv ***
// pin-side stand-in: board signals feeding the pin inputs
// assumes the bench sets wanted levels; a skew keeps them off the clock
`timescale 1ns/1ps
module gdb_pin_model (
	input  wire logic [63:0] want,
	output logic      [63:0] pin_in
);
	// idle lines sit high, as the sync flops preset to one
	initial pin_in = '1;
	// levels move only when asked, 7 ns late so never on an edge
	always @(want)
		pin_in <= #7 want;
endmodule

// *** dv/gdb_top_sva.sv ***
// assertion checker for the gpio data and event bank
// sees only top ports; bound from the testbench top file
`timescale 1ns/1ps
module gdb_top_sva (
	input wire logic        clk_sys,
	input wire logic        rst_n,
	input wire logic [5:0]  io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [31:0] io_wdata,
	input wire logic [31:0] io_rdata,
	input wire logic [63:0] pin_out,
	input wire logic [63:0] pin_lock,
	input wire logic        route_sel,
	input wire logic        sci_global_en,
	input wire logic        sci_req,
	input wire logic        smi_req,
	input wire logic        smi_top_sts,
	input wire logic        cfg_bank,
	input wire logic [4:0]  cfg_pin
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic out_wr; // a write aimed at either output latch
	assign out_wr = io_wr && (io_addr == gdb_pkg::OFF_OUT_LO
		|| io_addr == gdb_pkg::OFF_OUT_HI);
	property p_out_lo;
		io_wr && io_addr == gdb_pkg::OFF_OUT_LO |=> pin_out[31:0] ==
			($past(io_wdata) & ~$past(pin_lock[31:0])
			| $past(pin_out[31:0]) & $past(pin_lock[31:0]));
	endproperty
	a_out_lo: assert property (p_out_lo)
		else $error("low latch write wrong");
	property p_out_hold;
		!out_wr |=> $stable(pin_out);
	endproperty
	a_out_hold: assert property (p_out_hold)
		else $error("latch moved without write");
	property p_rd_out;
		io_rd && io_addr == gdb_pkg::OFF_OUT_LO |=>
			io_rdata == $past(pin_out[31:0]);
	endproperty
	a_rd_out: assert property (p_rd_out)
		else $error("latch readback wrong");
	property p_rd_hold;
		!io_rd |=> $stable(io_rdata);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read data moved");
	property p_sci;
		sci_req |-> ($past(route_sel) != gdb_pkg::ROUTE_SMI)
			&& $past(sci_global_en);
	endproperty
	a_sci: assert property (p_sci)
		else $error("control irq without route or enable");
	property p_smi_eq;
		smi_req == smi_top_sts;
	endproperty
	a_smi_eq: assert property (p_smi_eq)
		else $error("management irq not top status");
	property p_smi_route;
		$rose(smi_top_sts) |-> $past(route_sel) == gdb_pkg::ROUTE_SMI;
	endproperty
	a_smi_route: assert property (p_smi_route)
		else $error("management status in control route");
	property p_cfg;
		io_wr && io_addr == gdb_pkg::OFF_CSEL |=>
			{cfg_bank, cfg_pin} == $past(io_wdata[5:0]);
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("select fields wrong");
endmodule

// *** dv/gdb_top_tb_top.sv ***
// self-checking bench for the gpio data and event bank
// assumes a 40 MHz clock and the pin model standing in for the board
`timescale 1ns/1ps
`define CK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module gdb_top_tb_top;
	logic        clk_sys, rst_n, io_wr, io_rd, route_sel, sci_global_en;
	logic [5:0]  io_addr;
	logic [31:0] io_wdata, io_rdata;
	logic [63:0] pin_in, pin_out, pin_lock, event_edge_sense, want;
	logic        pme_aggregate, sci_req, smi_req, smi_second_sts;
	logic        smi_top_sts, cfg_bank;
	logic [4:0]  cfg_pin;
	int          bad_count = 0;
	int          n_checks = 0;
	gdb_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .pin_in(pin_in), .pin_out(pin_out),
		.pin_lock(pin_lock), .event_edge_sense(event_edge_sense),
		.route_sel(route_sel), .sci_global_en(sci_global_en),
		.pme_aggregate(pme_aggregate), .sci_req(sci_req),
		.smi_req(smi_req), .smi_second_sts(smi_second_sts),
		.smi_top_sts(smi_top_sts), .cfg_bank(cfg_bank), .cfg_pin(cfg_pin));
	gdb_pin_model u_pins (.want(want), .pin_in(pin_in));
	// 25 ns system clock
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// one-cycle strobes launched at the falling edge
	task wr(input logic [5:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clk_sys);
		io_wr = 1'b0;
	endtask
	task chk_rd(input logic [5:0] a, input logic [31:0] e);
		@(negedge clk_sys);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clk_sys);
		io_rd = 1'b0;
		`CK(io_rdata, e)
	endtask
	// bounded wait for the aggregate event flag
	task wt_evt;
		for (int i = 0; i < 20 && pme_aggregate !== 1'b1; i++)
			@(negedge clk_sys);
	endtask
	task t_reset;
		`CK(pin_out, {2{gdb_pkg::RST_OUT}})
		chk_rd(gdb_pkg::OFF_OUT_HI, gdb_pkg::RST_OUT);
		chk_rd(gdb_pkg::OFF_EEN_LO, 32'h00000000);
		chk_rd(gdb_pkg::OFF_EST_HI, 32'h00000000);
		chk_rd(gdb_pkg::OFF_CSEL, 32'h00000000);
		`CK(smi_second_sts, 1'b0)
		`CK(smi_top_sts, 1'b0)
		$display("test reset done");
	endtask
	// pin 0 and pin 32 locked, so their old ones survive
	task t_out;
		pin_lock = 64'h00000001_00000001;
		wr(gdb_pkg::OFF_OUT_LO, 32'h12345670);
		wr(gdb_pkg::OFF_OUT_HI, 32'hcafe0000);
		chk_rd(gdb_pkg::OFF_OUT_LO, 32'h12345671);
		chk_rd(gdb_pkg::OFF_OUT_HI, 32'hcafe0001);
		`CK(pin_out, 64'hcafe0001_12345671)
		`CK(pin_out[32], 1'b1)
		$display("test out done");
	endtask
	task t_csel;
		wr(gdb_pkg::OFF_CSEL, 32'h00000025);
		`CK({cfg_bank, cfg_pin}, 6'h25)
		chk_rd(gdb_pkg::OFF_CSEL, 32'h00000025);
		wr(gdb_pkg::OFF_CSEL, 32'h0000001f);
		`CK({cfg_bank, cfg_pin}, 6'h1f)
		$display("test csel done");
	endtask
	task t_evt;
		wr(gdb_pkg::OFF_EEN_LO, 32'h00000008);
		want[3] = 1'b0;
		want[16] = 1'b0;
		wt_evt;
		`CK(smi_req, 1'b1)
		`CK(smi_second_sts, 1'b1)
		`CK(sci_req, 1'b0)
		chk_rd(gdb_pkg::OFF_EST_LO, 32'h00000008);
		wr(gdb_pkg::OFF_EST_LO, 32'h00000000);
		chk_rd(gdb_pkg::OFF_EST_LO, 32'h00000008);
		`CK(smi_top_sts, 1'b1)
		wr(gdb_pkg::OFF_EST_LO, 32'h00000008);
		repeat (2) @(negedge clk_sys);
		`CK(smi_top_sts, 1'b0)
		`CK(smi_second_sts, 1'b0)
		chk_rd(gdb_pkg::OFF_EST_LO, 32'h00000000);
		route_sel = 1'b1;
		sci_global_en = 1'b1;
		event_edge_sense[33] = 1'b1;
		wr(gdb_pkg::OFF_EEN_HI, 32'h00000002);
		want[33] = 1'b0;
		repeat (6) @(negedge clk_sys);
		chk_rd(gdb_pkg::OFF_EST_HI, 32'h00000000);
		want[33] = 1'b1;
		wt_evt;
		`CK(sci_req, 1'b1)
		`CK(smi_top_sts, 1'b0)
		sci_global_en = 1'b0;
		repeat (2) @(negedge clk_sys);
		`CK(sci_req, 1'b0)
		`CK(pme_aggregate, 1'b1)
		wr(gdb_pkg::OFF_EST_HI, 32'h00000002);
		repeat (2) @(negedge clk_sys);
		`CK(pme_aggregate, 1'b0)
		$display("test evt done");
	endtask
	// falls on disabled event pins set status but no aggregate
	task t_lvl;
		want = 64'h01234567_89abcdef;
		repeat (4) @(negedge clk_sys);
		chk_rd(gdb_pkg::OFF_LVL_LO, 32'h89abcdef);
		chk_rd(gdb_pkg::OFF_LVL_HI, 32'h01234567);
		`CK(pme_aggregate, 1'b0)
		chk_rd(gdb_pkg::OFF_EST_LO, 32'h00003210);
		chk_rd(gdb_pkg::OFF_EST_HI, 32'h0000ba98);
		wr(gdb_pkg::OFF_LVL_LO, 32'h00000000);
		chk_rd(gdb_pkg::OFF_LVL_LO, 32'h89abcdef);
		`CK(pin_out, 64'hcafe0001_12345671)
		chk_rd(6'h3c, 32'h00000000);
		$display("test lvl done");
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// main sequence: sync reset held 12 cycles
	initial begin
		rst_n = 1'b0;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_addr = 6'h00;
		io_wdata = 32'h00000000;
		pin_lock = '0;
		event_edge_sense = '0;
		route_sel = gdb_pkg::ROUTE_SMI;
		sci_global_en = 1'b0;
		want = '1;
		repeat (12) @(negedge clk_sys);
		rst_n = 1'b1;
		t_reset;
		t_out;
		t_csel;
		t_evt;
		t_lvl;
		summarize;
	end
	// watchdog: tests need well under 1000 cycles
	initial begin
		#500000;
		bad_count++;
		summarize;
	end
endmodule
bind gdb_top gdb_top_sva u_sva (.clk_sys(clk_sys), .rst_n(rst_n),
	.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
	.io_rdata(io_rdata), .pin_out(pin_out), .pin_lock(pin_lock),
	.route_sel(route_sel), .sci_global_en(sci_global_en),
	.sci_req(sci_req), .smi_req(smi_req), .smi_top_sts(smi_top_sts),
	.cfg_bank(cfg_bank), .cfg_pin(cfg_pin));
